// ==== inc/vsc_pkg.sv ====
package vsc_pkg;
   // register word indices; byte address is four times the index
   localparam logic [3:0] A_CMD = 4'h0;
   localparam logic [3:0] A_DEVHEAD = 4'h1;
   localparam logic [3:0] A_LBA_LO = 4'h2;
   localparam logic [3:0] A_LBA_MID = 4'h3;
   localparam logic [3:0] A_LBA_HI = 4'h4;
   localparam logic [3:0] A_SECCNT = 4'h5;
   localparam logic [3:0] A_FEAT = 4'h6;
   localparam logic [3:0] A_DEVCTL = 4'h7;
   localparam logic [3:0] A_STATUS = 4'h8;
   localparam logic [3:0] A_ERROR = 4'h9;
   localparam logic [3:0] A_DATA = 4'hA;
   localparam logic [3:0] A_IRQ_STAT = 4'hB;
   localparam logic [3:0] A_IRQ_MASK = 4'hC;
   localparam logic [3:0] A_SEC_CFG = 4'hD;
   localparam logic [3:0] A_PW_SEL = 4'hE;
   localparam logic [3:0] A_PW_DATA = 4'hF;
   // opcodes
   localparam logic [7:0] OP_VER28A = 8'h40;
   localparam logic [7:0] OP_VER28B = 8'h41;
   localparam logic [7:0] OP_VER48 = 8'h42;
   localparam logic [3:0] OP_RECAL_HI = 4'h1;
   localparam logic [7:0] OP_SETPW = 8'hF1;
   localparam logic [7:0] OP_UNLOCK = 8'hF2;
   localparam logic [7:0] OP_PREP = 8'hF3;
   localparam logic [7:0] OP_ERASE = 8'hF4;
   localparam logic [7:0] OP_FREEZE = 8'hF5;
   localparam logic [7:0] OP_DISPW = 8'hF6;
   // field positions
   localparam int ST_BSY = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_UNC = 6;
   localparam int ER_ABRT = 2;
   localparam int DH_LBA = 6;
   localparam int DC_HOB = 7;
   localparam int IR_DONE = 0;
   localparam int IR_ABRT = 1;
   localparam int IR_MERR = 2;
   localparam int CF_SUP = 0;
   localparam int CF_LOCK = 1;
   localparam int CF_FRZ = 2;
   localparam int CF_ARM = 3;
   // payload sector layout
   localparam logic [7:0] PW_FIRST = 8'h01;
   localparam logic [7:0] PW_LAST = 8'h10;
   localparam logic [7:0] SEC_LAST = 8'hFF;
   // reset values and full counts
   localparam logic [7:0] DEVHEAD_RST = 8'hE0;
   localparam logic CFG_SUP_RST = 1'b1;
   localparam logic [16:0] CNT28_FULL = 17'h00100;
   localparam logic [16:0] CNT48_FULL = 17'h10000;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_MREQ = 3'b001,
      S_MWAIT = 3'b011,
      S_PAY = 3'b010,
      S_EXEC = 3'b110
   } vsc_state_t;
endpackage

// ==== rtl/vsc_pwbank.sv ====
`timescale 1ns/1ps
module vsc_pwbank
   import vsc_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic sys_rst, // sync reset
   input wire logic st_we, // stored password word write
   input wire logic st_sel, // 0 user, 1 master
   input wire logic [3:0] st_idx, // stored word index
   input wire logic [15:0] st_data, // stored word value
   input wire logic pl_we, // payload word write
   input wire logic [3:0] pl_idx, // payload word index
   input wire logic [15:0] pl_data, // payload word value
   input wire logic cmp_sel, // which stored password to compare
   output logic match // payload equals selected password
);
   logic [15:0] stored [2][16];
   logic [15:0] next_stored [2][16];
   logic [15:0] payload [16];
   logic [15:0] next_payload [16];

   always_comb begin
      next_stored = stored;
      next_payload = payload;
      if (st_we) begin
         next_stored[st_sel][st_idx] = st_data;
      end
      if (pl_we) begin
         next_payload[pl_idx] = pl_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stored <= '{default: '{default: 16'h0000}};
         payload <= '{default: 16'h0000};
      end else begin
         stored <= next_stored;
         payload <= next_payload;
      end
   end

   assign match = (payload == stored[cmp_sel]);
endmodule // vsc_pwbank

// ==== rtl/vsc_ata_sec.sv ====
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - verify: busy, no data request, then interrupt
// - verify error: stop, hold address, remaining count
// - 48-bit verify leaves last verified address
// - recalibrate group completes as no-operation
// - disable password clears lock on match
// - disable password keeps stored master password
// - payload: control word, 16 password words
// - erase unit aborts on password mismatch
// - erase unit needs prepare just before it
// - frozen rejects password and erase commands
// - only hardware reset clears frozen state
// - freeze while frozen completes, stays frozen
// - no security support: freeze becomes wear-level
// - prepare arms erase against accidental use
// - high-order select picks previous or current byte
module vsc_ata_sec
   import vsc_pkg::*;
(
   input wire logic clk, // core clock, 40 MHz
   input wire logic sys_rst, // sync reset, active high
   input wire logic [3:0] avs_address, // word index
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   output logic irq, // level interrupt
   output logic med_req, // sector check pulse
   output logic [48-1:0] med_lba, // sector to check
   input wire logic med_done, // sector check finished
   input wire logic med_err, // sector check failed
   output logic erase_req, // erase pulse
   output logic wear_req // wear-level pulse
);
   logic [7:0] cmd, devhead, feat, devctl, errreg, cnt_cur, cnt_prev;
   logic [7:0] next_cmd, next_devhead, next_feat, next_devctl, next_errreg;
   logic [7:0] next_cnt_cur, next_cnt_prev;
   logic [7:0] lba_cur [3];
   logic [7:0] lba_prev [3];
   logic [7:0] next_lba_cur [3];
   logic [7:0] next_lba_prev [3];
   logic bsy, drq, err, sup, locked, frozen, armed, is48, cmp_sel;
   logic next_bsy, next_drq, next_err, next_sup, next_locked;
   logic next_frozen, next_armed, next_is48, next_cmp_sel;
   logic [2:0] istat, imask, next_istat, next_imask;
   logic [4:0] pw_ptr, next_pw_ptr;
   logic [7:0] widx, next_widx;
   logic [16:0] remain, next_remain;
   logic [47:0] next_med_lba;
   logic [31:0] next_rdata;
   logic next_wait, next_irq, next_med_req, next_erase, next_wear;
   vsc_state_t state, next_state;
   logic req, wr_go, cmd_go, match, st_we, pl_we;
   logic [7:0] wd8;

   // =========================================================
   // bus slave: one wait cycle, then answer
   // =========================================================
   assign req = avs_read | avs_write;
   assign wr_go = avs_write & ~avs_waitrequest;
   assign wd8 = avs_writedata[7:0];
   assign cmd_go = wr_go && avs_address == A_CMD && state == S_IDLE;
   assign st_we = wr_go && avs_address == A_PW_DATA;
   assign pl_we = wr_go && avs_address == A_DATA && state == S_PAY
                  && widx >= PW_FIRST && widx <= PW_LAST;

   function automatic logic [7:0] hob_pick(input logic [7:0] prev,
                                           input logic [7:0] cur,
                                           input logic hob);
      return hob ? prev : cur;
   endfunction

   always_comb begin
      next_wait = ~(req & avs_waitrequest);
      next_rdata = avs_readdata;
      if (req && avs_waitrequest) begin
         next_rdata = 32'h0000_0000;
         case (avs_address)
            A_CMD: next_rdata[7:0] = cmd;
            A_DEVHEAD: next_rdata[7:0] = devhead;
            A_LBA_LO: next_rdata[7:0] =
               hob_pick(lba_prev[0], lba_cur[0], devctl[DC_HOB]);
            A_LBA_MID: next_rdata[7:0] =
               hob_pick(lba_prev[1], lba_cur[1], devctl[DC_HOB]);
            A_LBA_HI: next_rdata[7:0] =
               hob_pick(lba_prev[2], lba_cur[2], devctl[DC_HOB]);
            A_SECCNT: next_rdata[7:0] =
               hob_pick(cnt_prev, cnt_cur, devctl[DC_HOB]);
            A_FEAT: next_rdata[7:0] = feat;
            A_DEVCTL: next_rdata[7:0] = devctl;
            A_STATUS: begin
               next_rdata[ST_BSY] = bsy;
               next_rdata[ST_DRDY] = ~bsy;
               next_rdata[ST_DRQ] = drq;
               next_rdata[ST_ERR] = err;
            end
            A_ERROR: next_rdata[7:0] = errreg;
            A_IRQ_STAT: next_rdata[2:0] = istat;
            A_IRQ_MASK: next_rdata[2:0] = imask;
            A_SEC_CFG: next_rdata[3:0] = {armed, frozen, locked, sup};
            A_PW_SEL: next_rdata[4:0] = pw_ptr;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // =========================================================
   // task file, security state and command sequencer
   // =========================================================
   always_comb begin
      logic fin, abrt, merr;
      fin = 1'b0;
      abrt = 1'b0;
      merr = 1'b0;
      next_state = state;
      next_cmd = cmd;
      next_devhead = devhead;
      next_feat = feat;
      next_devctl = devctl;
      next_errreg = errreg;
      next_cnt_cur = cnt_cur;
      next_cnt_prev = cnt_prev;
      next_lba_cur = lba_cur;
      next_lba_prev = lba_prev;
      next_bsy = bsy;
      next_drq = drq;
      next_err = err;
      next_sup = sup;
      next_locked = locked;
      next_frozen = frozen;
      next_armed = armed;
      next_is48 = is48;
      next_cmp_sel = cmp_sel;
      next_imask = imask;
      next_pw_ptr = pw_ptr;
      next_widx = widx;
      next_remain = remain;
      next_med_lba = med_lba;
      next_med_req = 1'b0;
      next_erase = 1'b0;
      next_wear = 1'b0;
      // task file is read-only while busy, as a drive would do
      if (wr_go && state == S_IDLE) begin
         case (avs_address)
            A_DEVHEAD: next_devhead = wd8;
            A_LBA_LO: begin
               next_lba_prev[0] = lba_cur[0];
               next_lba_cur[0] = wd8;
            end
            A_LBA_MID: begin
               next_lba_prev[1] = lba_cur[1];
               next_lba_cur[1] = wd8;
            end
            A_LBA_HI: begin
               next_lba_prev[2] = lba_cur[2];
               next_lba_cur[2] = wd8;
            end
            A_SECCNT: begin
               next_cnt_prev = cnt_cur;
               next_cnt_cur = wd8;
            end
            A_FEAT: next_feat = wd8;
            default: ;
         endcase
      end
      if (wr_go) begin
         case (avs_address)
            A_DEVCTL: next_devctl = wd8;
            A_IRQ_MASK: next_imask = avs_writedata[2:0];
            A_SEC_CFG: begin
               next_sup = avs_writedata[CF_SUP];
               next_locked = avs_writedata[CF_LOCK];
            end
            A_PW_SEL: next_pw_ptr = avs_writedata[4:0];
            A_PW_DATA: next_pw_ptr = pw_ptr + 5'h01;
            default: ;
         endcase
      end
      case (state)
         S_IDLE: begin
            if (cmd_go) begin
               next_cmd = wd8;
               next_bsy = 1'b1;
               next_err = 1'b0;
               next_errreg = 8'h00;
               next_armed = 1'b0;
               next_widx = 8'h00;
               if (wd8 == OP_VER28A || wd8 == OP_VER28B) begin
                  if (!devhead[DH_LBA]) begin
                     abrt = 1'b1;
                  end else begin
                     next_is48 = 1'b0;
                     next_med_lba = {20'h00000, devhead[3:0],
                        lba_cur[2], lba_cur[1], lba_cur[0]};
                     next_remain = (cnt_cur == 8'h00) ? CNT28_FULL
                                   : {9'h000, cnt_cur};
                     next_state = S_MREQ;
                  end
               end else if (wd8 == OP_VER48) begin
                  next_is48 = 1'b1;
                  next_med_lba = {lba_prev[2], lba_prev[1], lba_prev[0],
                     lba_cur[2], lba_cur[1], lba_cur[0]};
                  next_remain = ({cnt_prev, cnt_cur} == 16'h0000)
                                ? CNT48_FULL : {1'b0, cnt_prev, cnt_cur};
                  next_state = S_MREQ;
               end else if (wd8[7:4] == OP_RECAL_HI) begin
                  fin = 1'b1;
               end else if (wd8 == OP_PREP) begin
                  // arm for the next command only
                  next_armed = 1'b1;
                  fin = 1'b1;
               end else if (wd8 == OP_FREEZE) begin
                  fin = 1'b1;
                  if (sup) begin
                     next_frozen = 1'b1;
                  end else begin
                     next_wear = 1'b1;
                  end
               end else if (wd8 == OP_DISPW && !frozen) begin
                  next_drq = 1'b1;
                  next_state = S_PAY;
               end else if (wd8 == OP_ERASE && !frozen && armed) begin
                  next_drq = 1'b1;
                  next_state = S_PAY;
               end else begin
                  abrt = 1'b1;
               end
            end
         end
         S_MREQ: begin
            next_med_req = 1'b1;
            next_state = S_MWAIT;
         end
         S_MWAIT: begin
            if (med_done) begin
               if (med_err || remain == 17'h00001) begin
                  // hold failing address and count left
                  fin = ~med_err;
                  merr = med_err;
                  next_cnt_cur = med_err ? remain[7:0] : 8'h00;
                  next_lba_cur[0] = med_lba[7:0];
                  next_lba_cur[1] = med_lba[15:8];
                  next_lba_cur[2] = med_lba[23:16];
                  if (is48) begin
                     next_cnt_prev = med_err ? remain[15:8] : 8'h00;
                     next_lba_prev[0] = med_lba[31:24];
                     next_lba_prev[1] = med_lba[39:32];
                     next_lba_prev[2] = med_lba[47:40];
                  end else begin
                     next_devhead[3:0] = med_lba[27:24];
                  end
               end else begin
                  next_remain = remain - 17'h00001;
                  next_med_lba = med_lba + 48'h0000_0000_0001;
                  next_state = S_MREQ;
               end
            end
         end
         S_PAY: begin
            if (wr_go && avs_address == A_DATA) begin
               // word 0 bit 0 picks master
               if (widx == 8'h00) begin
                  next_cmp_sel = avs_writedata[0];
               end
               next_widx = widx + 8'h01;
               if (widx == SEC_LAST) begin
                  next_drq = 1'b0;
                  next_state = S_EXEC;
               end
            end
         end
         S_EXEC: begin
            if (!match) begin
               abrt = 1'b1;
            end else if (cmd == OP_ERASE) begin
               next_erase = 1'b1;
               next_locked = 1'b0;
               fin = 1'b1;
            end else begin
               next_locked = 1'b0;
               fin = 1'b1;
            end
         end
         default: next_state = S_IDLE;
      endcase
      if (fin || abrt || merr) begin
         next_bsy = 1'b0;
         next_drq = 1'b0;
         next_err = abrt | merr;
         next_errreg[ER_ABRT] = abrt;
         next_errreg[ER_UNC] = merr;
         next_state = S_IDLE;
      end
      // set wins over a write-one clear in the same cycle
      next_istat = istat;
      if (wr_go && avs_address == A_IRQ_STAT) begin
         next_istat = istat & ~avs_writedata[2:0];
      end
      next_istat = next_istat | {merr, abrt, fin | merr | abrt};
      next_irq = |(next_istat & next_imask);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= S_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
         cmd <= 8'h00;
         devhead <= DEVHEAD_RST;
         feat <= 8'h00;
         devctl <= 8'h00;
         errreg <= 8'h00;
         cnt_cur <= 8'h00;
         cnt_prev <= 8'h00;
         lba_cur <= '{default: 8'h00};
         lba_prev <= '{default: 8'h00};
         bsy <= 1'b0;
         drq <= 1'b0;
         err <= 1'b0;
         sup <= CFG_SUP_RST;
         locked <= 1'b0;
         frozen <= 1'b0;
         armed <= 1'b0;
         is48 <= 1'b0;
         cmp_sel <= 1'b0;
         istat <= 3'h0;
         imask <= 3'h0;
         pw_ptr <= 5'h00;
         widx <= 8'h00;
         remain <= 17'h00000;
         med_lba <= 48'h0000_0000_0000;
         med_req <= 1'b0;
         erase_req <= 1'b0;
         wear_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         avs_waitrequest <= next_wait;
         avs_readdata <= next_rdata;
         cmd <= next_cmd;
         devhead <= next_devhead;
         feat <= next_feat;
         devctl <= next_devctl;
         errreg <= next_errreg;
         cnt_cur <= next_cnt_cur;
         cnt_prev <= next_cnt_prev;
         lba_cur <= next_lba_cur;
         lba_prev <= next_lba_prev;
         bsy <= next_bsy;
         drq <= next_drq;
         err <= next_err;
         sup <= next_sup;
         locked <= next_locked;
         frozen <= next_frozen;
         armed <= next_armed;
         is48 <= next_is48;
         cmp_sel <= next_cmp_sel;
         istat <= next_istat;
         imask <= next_imask;
         pw_ptr <= next_pw_ptr;
         widx <= next_widx;
         remain <= next_remain;
         med_lba <= next_med_lba;
         med_req <= next_med_req;
         erase_req <= next_erase;
         wear_req <= next_wear;
         irq <= next_irq;
      end
   end

   vsc_pwbank u_pwbank (
      .clk(clk),
      .sys_rst(sys_rst),
      .st_we(st_we),
      .st_sel(pw_ptr[4]),
      .st_idx(pw_ptr[3:0]),
      .st_data(avs_writedata[15:0]),
      .pl_we(pl_we),
      .pl_idx(4'(widx - PW_FIRST)),
      .pl_data(avs_writedata[15:0]),
      .cmp_sel(cmp_sel),
      .match(match)
   );

   // =========================================================
   // checks
   // =========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_verify_nodrq: assert property (
      (state == S_MREQ || state == S_MWAIT) |-> bsy && !drq)
      else $error("data request during verify");
   chk_verify_done: assert property (
      state == S_MWAIT && med_done && !med_err && remain == 17'h00001
      |=> !bsy && istat[IR_DONE] && state == S_IDLE)
      else $error("verify did not finish with interrupt");
   chk_err_count: assert property (
      state == S_MWAIT && med_done && med_err
      |=> err && cnt_cur == $past(remain[7:0])
          && lba_cur[0] == $past(med_lba[7:0]))
      else $error("verify error did not hold place");
   chk_last_lba48: assert property (
      state == S_MWAIT && med_done && !med_err && is48
      && remain == 17'h00001
      |=> lba_prev[2] == $past(med_lba[47:40]) && !err)
      else $error("last verified address lost");
   chk_recal_nop: assert property (
      cmd_go && wd8[7:4] == OP_RECAL_HI
      |=> !bsy && !err ##1 !med_req)
      else $error("recalibrate touched medium");
   chk_erase_unarmed: assert property (
      cmd_go && wd8 == OP_ERASE && !armed
      |=> err && errreg[ER_ABRT] && !drq)
      else $error("unarmed erase accepted");
   chk_frozen_reject: assert property (
      cmd_go && frozen && (wd8 == OP_DISPW || wd8 == OP_ERASE)
      |=> err && state == S_IDLE)
      else $error("frozen device took lock command");
   chk_frozen_hold: assert property (
      frozen |=> frozen)
      else $error("frozen state left without reset");
   chk_dis_mismatch: assert property (
      state == S_EXEC && !match
      |=> err && locked == $past(locked) && istat[IR_ABRT])
      else $error("mismatch did not abort");
   chk_erase_pulse: assert property (
      erase_req |-> $past(state) == S_EXEC && $past(match)
      && $past(cmd) == OP_ERASE)
      else $error("erase without matching password");

   cov_verify_ok: cover property (
      state == S_MWAIT && med_done && !med_err ##1 state == S_IDLE);
   cov_verify_err: cover property (state == S_MWAIT && med_done && med_err);
   cov_erase: cover property (erase_req);
   cov_refreeze: cover property (cmd_go && wd8 == OP_FREEZE && frozen);
endmodule // vsc_ata_sec

// ==== bench/vsc_medium.sv ====
`timescale 1ns/1ps
module vsc_medium (
   input wire logic clk, // core clock
   input wire logic med_req, // sector check request
   input wire logic [47:0] med_lba, // sector to check
   input wire logic [47:0] bad_lba, // sector that fails
   output logic med_done = 1'b0, // check finished
   output logic med_err = 1'b0 // check failed
);
   logic [2:0] wait_cnt = 3'h0;
   logic fail = 1'b0;
   // ==========
   // slow medium
   // fails only the chosen sector
   // err toggles outside done, so it is never trusted there
   always @(posedge clk) begin
      med_done <= 1'b0;
      med_err <= ~med_err;
      if (med_req) begin
         wait_cnt <= 3'h4;
         fail <= (med_lba == bad_lba);
      end else if (wait_cnt == 3'h1) begin
         wait_cnt <= 3'h0;
         med_done <= 1'b1;
         med_err <= fail;
      end else if (wait_cnt != 3'h0) begin
         wait_cnt <= wait_cnt - 3'h1;
      end
   end
endmodule // vsc_medium

// ==== bench/vsc_ata_sec_test.sv ====
`timescale 1ns/1ps
module vsc_ata_sec_test;
   import vsc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [3:0] ad = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat, q;
   logic wt, irq, mq, md, me, er, wl;
   logic [47:0] ml;
   logic [47:0] bad = 48'hFFFF;
   logic [7:0] frz_op [4] = '{OP_DISPW, OP_ERASE, OP_SETPW, OP_UNLOCK};
   int mismatches, cmp_count, nerase, nwear, nreq, i;
   vsc_ata_sec vsc_ata_sec_inst (.clk(clk), .sys_rst(sys_rst),
      .avs_address(ad), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdat), .avs_waitrequest(wt), .irq(irq), .med_req(mq),
      .med_lba(ml), .med_done(md), .med_err(me), .erase_req(er),
      .wear_req(wl));
   vsc_medium vsc_medium_inst (.clk(clk), .med_req(mq), .med_lba(ml),
      .bad_lba(bad), .med_done(md), .med_err(me));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (er === 1'b1) nerase++;
      if (wl === 1'b1) nwear++;
      if (mq === 1'b1) nreq++;
   end
   // ==========
   // tasks
   task automatic give_verdict;
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 20);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         give_verdict;
      end
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // payload: word0 selects, words 1..16 password, rest zero
   task automatic cmd(input logic [7:0] op, input int pay,
      input logic [15:0] w0, input logic [15:0] base, input logic [31:0] e);
      int n;
      logic [15:0] v;
      acc(1'b1, A_IRQ_STAT, 32'h7);
      acc(1'b1, A_CMD, {24'h0, op});
      for (n = 0; n < 256 && pay != 0; n++) begin
         v = (n == 0) ? w0 : ((n <= 16) ? base + n[15:0] : 16'h0);
         acc(1'b1, A_DATA, {16'h0, v});
      end
      n = 0;
      do begin
         acc(1'b0, A_STATUS, 32'h0);
         n++;
      end while ((q[ST_BSY] | q[ST_DRQ]) !== 1'b0 && n < 99);
      if (n >= 99) begin
         mismatches++;
         give_verdict;
      end
      rc(A_IRQ_STAT, e);
   endtask
   // ==========
   // sequence
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rc(A_DEVHEAD, 32'hE0);
      rc(A_SEC_CFG, 32'h1);
      acc(1'b1, A_IRQ_MASK, 32'h7);
      acc(1'b1, A_LBA_LO, 32'h20);
      acc(1'b1, A_SECCNT, 32'h2);
      cmd(OP_VER28A, 0, 16'h0, 16'h0, 32'h1);
      rc(A_LBA_LO, 32'h21);
      chk({31'h0, irq}, 32'h1);
      bad <= 48'h11;
      acc(1'b1, A_LBA_LO, 32'h10);
      acc(1'b1, A_SECCNT, 32'h3);
      cmd(OP_VER28B, 0, 16'h0, 16'h0, 32'h5);
      rc(A_LBA_LO, 32'h11);
      rc(A_SECCNT, 32'h2);
      rc(A_ERROR, 32'h40);
      acc(1'b1, A_DEVHEAD, 32'hA0);
      cmd(OP_VER28A, 0, 16'h0, 16'h0, 32'h3);
      acc(1'b1, A_DEVHEAD, 32'hE0);
      for (i = 0; i < 2; i++) begin
         acc(1'b1, A_LBA_HI, (i == 0) ? 32'h1 : 32'h0);
         acc(1'b1, A_LBA_MID, 32'h0);
         acc(1'b1, A_LBA_LO, (i == 0) ? 32'h0 : 32'h5);
         acc(1'b1, A_SECCNT, (i == 0) ? 32'h0 : 32'h2);
      end
      cmd(OP_VER48, 0, 16'h0, 16'h0, 32'h1);
      acc(1'b1, A_DEVCTL, 32'h80);
      rc(A_LBA_HI, 32'h1);
      acc(1'b1, A_DEVCTL, 32'h0);
      rc(A_LBA_LO, 32'h6);
      rc(A_SECCNT, 32'h0);
      acc(1'b1, A_IRQ_MASK, 32'h0);
      for (i = 8'h10; i <= 8'h1F; i += 15) begin
         cmd(i[7:0], 0, 16'h0, 16'h0, 32'h1);
      end
      chk({31'h0, irq}, 32'h0);
      chk(nreq, 32'h6);
      acc(1'b1, A_IRQ_MASK, 32'h7);
      for (i = 0; i < 32; i++) begin
         if (i % 16 == 0) acc(1'b1, A_PW_SEL, i);
         acc(1'b1, A_PW_DATA, 32'h1001 + i[4] * 32'h1000 + i[3:0]);
      end
      acc(1'b1, A_SEC_CFG, 32'h3);
      cmd(OP_DISPW, 1, 16'h0, 16'h3000, 32'h3);
      rc(A_SEC_CFG, 32'h3);
      cmd(OP_DISPW, 1, 16'h1, 16'h2000, 32'h1);
      rc(A_SEC_CFG, 32'h1);
      cmd(OP_PREP, 0, 16'h0, 16'h0, 32'h1);
      cmd(OP_ERASE, 1, 16'h1, 16'h2000, 32'h1);
      cmd(OP_PREP, 0, 16'h0, 16'h0, 32'h1);
      cmd(OP_ERASE, 1, 16'h0, 16'h3000, 32'h3);
      cmd(OP_PREP, 0, 16'h0, 16'h0, 32'h1);
      cmd(8'h10, 0, 16'h0, 16'h0, 32'h1);
      cmd(OP_ERASE, 0, 16'h0, 16'h0, 32'h3);
      chk(nerase, 32'h1);
      cmd(OP_FREEZE, 0, 16'h0, 16'h0, 32'h1);
      cmd(OP_FREEZE, 0, 16'h0, 16'h0, 32'h1);
      for (i = 0; i < 4; i++) begin
         cmd(frz_op[i], 0, 16'h0, 16'h0, 32'h3);
      end
      rc(A_SEC_CFG, 32'h5);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rc(A_SEC_CFG, 32'h1);
      acc(1'b1, A_SEC_CFG, 32'h0);
      cmd(OP_FREEZE, 0, 16'h0, 16'h0, 32'h1);
      chk(nwear, 32'h1);
      rc(A_SEC_CFG, 32'h0);
      give_verdict;
   end
endmodule // vsc_ata_sec_test
